// ---- src/charge_bank_pkg.sv ----
// shared constants, types and bank decoding for the charge bank sequencer
package charge_bank_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;            // core_clk at 10 MHz
  localparam int SEC_NS         = 1_000_000_000;  // one regulation second
  localparam int SEC_CYCLES     = SEC_NS / CLK_PERIOD_NS;
  localparam int SER_BIT_NS     = 104_167;        // one bit at 9600 baud
  localparam int SER_BIT_CYCLES = SER_BIT_NS / CLK_PERIOD_NS;  // rounds down

  // ----------------------------------------------------------------------
  // regulator states and bank patterns (bit 0 = bank A .. bit 3 = bank D)
  // ----------------------------------------------------------------------
  localparam logic [3:0] STATE_RESET       = 4'h0;
  localparam logic [3:0] STATE_BOOST_LAST  = 4'h3;
  localparam logic [3:0] STATE_FLOAT_FIRST = 4'h4;
  localparam logic [3:0] STATE_LAST        = 4'h8;
  localparam logic [3:0] BANKS_ALL         = 4'hF;
  localparam logic [3:0] BANKS_NONE        = 4'h0;
  localparam logic [3:0] BANK_IDX_LAST     = 4'h3;

  // ----------------------------------------------------------------------
  // self-test patterns
  // ----------------------------------------------------------------------
  localparam logic [3:0] NVM_TEST_ADDR = 4'h0;
  localparam logic [7:0] NVM_PATTERN   = 8'hA5;
  localparam logic [7:0] SER_PATTERN   = 8'h55;

  typedef enum logic [2:0] {
    TS_CHARGE, TS_LOAD, TS_MEM_WR, TS_MEM_RD, TS_BANKS, TS_STATES, TS_SERIAL
  } test_step_e;

  typedef enum logic [2:0] {
    ENT_IDLE, ENT_CAL, ENT_INC1, ENT_INC2, ENT_RUN
  } entry_e;

  // banks switched on in each regulator state; illegal codes give none
  function automatic logic [3:0] bank_mask(input logic [3:0] st);
    case (st)
      4'h0:    bank_mask = 4'hF;
      4'h1:    bank_mask = 4'h7;
      4'h2:    bank_mask = 4'h3;
      4'h3:    bank_mask = 4'h1;
      4'h4:    bank_mask = 4'h0;
      4'h5:    bank_mask = 4'h1;
      4'h6:    bank_mask = 4'h3;
      4'h7:    bank_mask = 4'h7;
      4'h8:    bank_mask = 4'hF;
      default: bank_mask = 4'h0;
    endcase
  endfunction

endpackage

// ---- src/nvm_scratch.sv ----
// small scratch memory exercised by the self-test write/read check
`timescale 1ns/1ns
module nvm_scratch
  import charge_bank_pkg::*;
(
  input  wire logic       core_clk, // system clock
  input  wire logic       sys_rst,  // synchronous reset, clears read data
  input  wire logic       wr_en,    // write strobe
  input  wire logic       rd_en,    // read strobe
  input  wire logic [3:0] addr,     // word address
  input  wire logic [7:0] wr_data,  // write data
  output logic      [7:0] rd_data   // registered read data
);

  logic [7:0] mem [16];

  // array has no reset; only the read register is cleared
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      rd_data <= mem[addr];
    end
  end

endmodule

// ---- src/key_entry.sv ----
// keypad synchroniser, self-test entry sequence, pause and exit control
`timescale 1ns/1ns
module key_entry
  import charge_bank_pkg::*;
(
  input  wire logic core_clk,      // system clock
  input  wire logic sys_rst,       // synchronous reset
  input  wire logic cal_key,       // calibration key pin, high pressed
  input  wire logic increment_key, // increment key pin, high pressed
  input  wire logic decrement_key, // decrement key pin, high pressed
  output logic      test_active,   // self-test running
  output logic      test_paused    // self-test frozen in its step
);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------------
  // two-stage synchronisers, then a third stage for edge detection
  // ----------------------------------------------------------------------
  logic [2:0] key_s1, key_s2, key_s3;
  entry_e     entry, next_entry;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      key_s1 <= 3'h0;
      key_s2 <= 3'h0;
      key_s3 <= 3'h0;
    end else begin
      key_s1 <= {decrement_key, increment_key, cal_key};
      key_s2 <= key_s1;
      key_s3 <= key_s2;
    end
  end

  wire [2:0] press   = key_s2 & ~key_s3;  // one pulse per key press
  wire       cal_p   = press[0];
  wire       inc_p   = press[1];
  wire       dec_p   = press[2];
  wire       any_p   = |press;

  // entry sequence: cal, inc, inc, cal; a stray key starts over, except in ENT_CAL where it is ignored
  always_comb begin
    next_entry = entry;
    case (entry)
      ENT_IDLE: if (cal_p) next_entry = ENT_CAL;                 // see [R7]
      ENT_CAL:  if (any_p) next_entry = inc_p ? ENT_INC1 : ENT_CAL;
      ENT_INC1: if (any_p) next_entry = inc_p ? ENT_INC2
                                     : (cal_p ? ENT_CAL : ENT_IDLE);
      ENT_INC2: if (any_p) next_entry = cal_p ? ENT_RUN : ENT_IDLE;
      ENT_RUN:  if (dec_p) next_entry = ENT_IDLE;                // see [R9]
      default:  next_entry = ENT_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      entry       <= ENT_IDLE;
      test_active <= 1'b0;
      test_paused <= 1'b0;
    end else begin
      entry       <= next_entry;
      test_active <= (next_entry == ENT_RUN);
      // decrement wins over a simultaneous increment
      if (next_entry != ENT_RUN) begin
        test_paused <= 1'b0;
      end else if (entry == ENT_RUN && inc_p) begin
        test_paused <= ~test_paused;                             // see [R8]
      end
    end
  end

  property p_dec_exit;
    test_active && dec_p |=> !test_active && !test_paused;
  endproperty
  a_dec_exit: assert property (p_dec_exit) // see [R9]
    else $error("decrement did not end self-test");

  property p_inc_toggle;
    test_active && inc_p && !dec_p |=> test_paused != $past(test_paused);
  endproperty
  a_inc_toggle: assert property (p_inc_toggle) // see [R8]
    else $error("increment did not toggle pause");

endmodule

// ---- src/charge_bank_state_sequencer.sv ----
// charge bank regulation state sequencer with hardware self-test cycle
`timescale 1ns/1ns
// Operation
// [R1] one of nine states selects the banks
// [R2] reset enters state 0, all banks on
// [R3] next state from state and voltage only
// [R4] boost states step after programmed delay
// [R5] float states step once per second
// [R6] boost stepping drops bank D first
// [R7] operator keys cal, inc, inc, cal
// [R8] increment pauses and resumes the test
// [R9] decrement ends the test
// [R10] test drives banks A, B, C, D singly
// [R11] alarm byte shows inputs 1..7 on bits 0..6
// [R12] memory check result is presented
// [R13] tester loops serial output to input
// [R14] test cycle charge, load, memory, states, serial; the code also runs a banks step between memory and states
// [R15] illegal state codes return to state 0
module charge_bank_state_sequencer
  import charge_bank_pkg::*;
#(
  parameter int SEC_COUNT = SEC_CYCLES  // cycles per regulation second
)(
  input  wire logic        core_clk,       // system clock, 10 MHz
  input  wire logic        sys_rst,        // synchronous reset, active high
  input  wire logic [11:0] batt_mv,        // measured battery voltage
  input  wire logic [11:0] boost_limit_mv, // boost step-off threshold
  input  wire logic [11:0] float_limit_mv, // float regulation threshold
  input  wire logic [7:0]  delay_sec,      // boost state change delay
  input  wire logic        cal_key,        // calibration key pin
  input  wire logic        increment_key,  // increment key pin
  input  wire logic        decrement_key,  // decrement key pin
  input  wire logic [6:0]  alarm_in,       // alarm inputs 1..7, high active
  output logic      [3:0]  bank_on,        // bank switches, bit 0 = bank A
  output logic             charge_on,      // charge path switch
  output logic             load_on,        // load switch
  output logic      [3:0]  shown_state,    // regulator or test state index
  output logic      [7:0]  alarm_byte,     // alarm input byte for display
  output logic             mem_pass,       // last memory check passed
  output logic             mem_fail,       // last memory check failed
  output logic             serial_tx,      // serial output, idle high
  output logic             test_active,    // self-test running
  output logic             test_paused     // self-test frozen
);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [23:0] sec_cnt;
  logic [7:0]  dly_cnt;
  logic [3:0]  reg_state, next_reg_state;
  test_step_e  test_step, next_step;
  logic [3:0]  test_idx, next_idx;
  logic        loop_flip;
  logic [10:0] ser_cnt;
  logic [9:0]  tx_shift;
  logic [6:0]  alarm_s1, alarm_s2;
  logic [7:0]  nvm_rd;
  logic [3:0]  next_bank;

  // ----------------------------------------------------------------------
  // keypad and self-test entry
  // ----------------------------------------------------------------------
  key_entry key_entry_i (
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .cal_key       (cal_key),
    .increment_key (increment_key),
    .decrement_key (decrement_key),
    .test_active   (test_active),
    .test_paused   (test_paused)
  );

  // ----------------------------------------------------------------------
  // one-second tick and boost delay
  // ----------------------------------------------------------------------
  wire tick      = (sec_cnt == 24'(SEC_COUNT - 1));
  wire in_boost  = (reg_state <= STATE_BOOST_LAST);
  wire in_float  = (reg_state >= STATE_FLOAT_FIRST) &&
                   (reg_state <= STATE_LAST);
  wire boost_due = tick && ({1'b0, dly_cnt} + 9'h001 >= {1'b0, delay_sec});
  wire eval      = !test_active &&
                   (in_boost ? boost_due : tick);  // see [R4] see [R5]

  // delay restarts whenever a boost evaluation fires
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sec_cnt <= 24'h0000;
      dly_cnt <= 8'h00;
    end else begin
      sec_cnt <= tick ? 24'h0000 : sec_cnt + 24'h0001;
      if (!in_boost || test_active || boost_due) begin
        dly_cnt <= 8'h00;
      end else if (tick) begin
        dly_cnt <= dly_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // regulation state choice: only state and battery voltage steer it
  // ----------------------------------------------------------------------
  wire boost_hi = (batt_mv > boost_limit_mv);
  wire float_hi = (batt_mv > float_limit_mv);

  always_comb begin
    next_reg_state = reg_state;
    if (eval) begin
      case (reg_state)                                           // see [R3]
        4'h0, 4'h1, 4'h2, 4'h3: begin
          // step toward state 4, shedding bank D first
          if (boost_hi) begin
            next_reg_state = reg_state + 4'h1;                   // see [R6]
          end else if (reg_state != STATE_RESET) begin
            next_reg_state = reg_state - 4'h1;
          end
        end
        4'h4, 4'h5, 4'h6, 4'h7, 4'h8: begin
          if (float_hi && reg_state != STATE_FLOAT_FIRST) begin
            next_reg_state = reg_state - 4'h1;
          end else if (!float_hi && reg_state != STATE_LAST) begin
            next_reg_state = reg_state + 4'h1;
          end
        end
        default: next_reg_state = STATE_RESET;                   // see [R15]
      endcase
    end else if (reg_state > STATE_LAST) begin
      next_reg_state = STATE_RESET;                              // see [R15]
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_state <= STATE_RESET;                                  // see [R2]
    end else begin
      reg_state <= next_reg_state;
    end
  end

  // ----------------------------------------------------------------------
  // self-test step sequence; a pause freezes the step and its index
  // ----------------------------------------------------------------------
  wire adv = test_active && !test_paused && tick;                // see [R8]

  always_comb begin
    next_step = test_step;
    next_idx  = test_idx;
    case (test_step)                                             // see [R14]
      TS_CHARGE: next_step = TS_LOAD;
      TS_LOAD:   next_step = TS_MEM_WR;
      TS_MEM_WR: next_step = TS_MEM_RD;
      TS_MEM_RD: next_step = TS_BANKS;
      TS_BANKS: begin
        if (test_idx == BANK_IDX_LAST) begin
          next_step = TS_STATES;
          next_idx  = 4'h0;
        end else begin
          next_idx  = test_idx + 4'h1;                           // see [R10]
        end
      end
      TS_STATES: begin
        if (test_idx == STATE_LAST) begin
          next_step = TS_SERIAL;
          next_idx  = 4'h0;
        end else begin
          next_idx  = test_idx + 4'h1;
        end
      end
      TS_SERIAL: next_step = TS_CHARGE;
      default:   next_step = TS_CHARGE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || !test_active) begin
      test_step <= TS_CHARGE;
      test_idx  <= 4'h0;
      loop_flip <= 1'b0;
    end else if (adv) begin
      test_step <= next_step;
      test_idx  <= next_idx;
      if (test_step == TS_SERIAL) begin
        loop_flip <= ~loop_flip;  // alternate pattern to catch stuck bits
      end
    end
  end

  // ----------------------------------------------------------------------
  // memory check: write in one step, read back and judge at its end
  // ----------------------------------------------------------------------
  wire [7:0] nvm_word = loop_flip ? ~NVM_PATTERN : NVM_PATTERN;

  nvm_scratch nvm_scratch_i (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wr_en    (test_active && test_step == TS_MEM_WR),
    .rd_en    (test_active && test_step == TS_MEM_RD),
    .addr     (NVM_TEST_ADDR),
    .wr_data  (nvm_word),
    .rd_data  (nvm_rd)
  );

  wire judge = adv && test_step == TS_MEM_RD;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem_pass <= 1'b0;
      mem_fail <= 1'b0;
    end else if (judge) begin
      mem_pass <= (nvm_rd == nvm_word);                          // see [R12]
      mem_fail <= (nvm_rd != nvm_word);
    end
  end

  // ----------------------------------------------------------------------
  // serial frame: start bit, pattern LSB first, stop bit, once per pass
  // ----------------------------------------------------------------------
  wire ser_bit = (ser_cnt == 11'(SER_BIT_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (sys_rst || test_step != TS_SERIAL) begin
      ser_cnt  <= 11'h000;
      tx_shift <= {1'b1, SER_PATTERN, 1'b0};
    end else begin
      ser_cnt <= ser_bit ? 11'h000 : ser_cnt + 11'h001;
      if (ser_bit) begin
        tx_shift <= {1'b1, tx_shift[9:1]};  // refills with idle level
      end
    end
  end

  // ----------------------------------------------------------------------
  // alarm inputs: synchronised, input 1 lands on bit 0
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      alarm_s1   <= 7'h00;
      alarm_s2   <= 7'h00;
      alarm_byte <= 8'h00;
    end else begin
      alarm_s1   <= alarm_in;
      alarm_s2   <= alarm_s1;
      alarm_byte <= {1'b0, alarm_s2};                            // see [R11]
    end
  end

  // ----------------------------------------------------------------------
  // switch outputs: test steps override the regulator pattern
  // ----------------------------------------------------------------------
  always_comb begin
    case (test_step)
      TS_BANKS:  next_bank = 4'h1 << test_idx[1:0];              // see [R10]
      TS_STATES: next_bank = bank_mask(test_idx);
      default:   next_bank = BANKS_NONE;
    endcase
    if (!test_active) begin
      next_bank = bank_mask(next_reg_state);                     // see [R1]
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bank_on     <= BANKS_ALL;                                  // see [R2]
      charge_on   <= 1'b1;
      load_on     <= 1'b1;
      shown_state <= STATE_RESET;
      serial_tx   <= 1'b1;
    end else begin
      bank_on     <= next_bank;
      charge_on   <= !test_active || test_step != TS_LOAD;       // see [R14]
      load_on     <= !test_active || test_step != TS_CHARGE;
      shown_state <= (test_active && test_step == TS_STATES) ?
                     test_idx : next_reg_state;
      serial_tx   <= (test_step == TS_SERIAL) ? tx_shift[0] : 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_reset;
    disable iff (1'b0) sys_rst |=> reg_state == STATE_RESET &&
                                   bank_on == BANKS_ALL;
  endproperty
  a_reset: assert property (p_reset) // see [R2]
    else $error("reset did not give state 0 with all banks");

  property p_bank_map;
    !test_active && !$past(test_active) |-> bank_on == bank_mask(reg_state);
  endproperty
  a_bank_map: assert property (p_bank_map) // see [R1]
    else $error("bank pattern does not match state");

  property p_legal;
    reg_state <= STATE_LAST;
  endproperty
  a_legal: assert property (p_legal) // see [R15]
    else $error("regulator state code out of range");

  property p_boost_hold;
    in_boost && !boost_due |=> $stable(reg_state);
  endproperty
  a_boost_hold: assert property (p_boost_hold) // see [R4]
    else $error("boost state moved before its delay");

  property p_float_hold;
    in_float && !tick |=> $stable(reg_state);
  endproperty
  a_float_hold: assert property (p_float_hold) // see [R5]
    else $error("float state moved between seconds");

  property p_float_down;
    in_float && tick && !test_active && float_hi &&
      reg_state != STATE_FLOAT_FIRST |=> reg_state == $past(reg_state) - 4'h1;
  endproperty
  a_float_down: assert property (p_float_down) // see [R3]
    else $error("high voltage in float did not shed a bank");

  sequence s_leave_full;
    !test_active && reg_state == STATE_RESET ##1 reg_state == 4'h1;
  endsequence
  property p_d_first;
    s_leave_full |-> bank_on == 4'h7;
  endproperty
  a_d_first: assert property (p_d_first) // see [R6]
    else $error("bank D was not the first switched off");

  property p_pause_hold;
    test_active && test_paused ##1 test_active |-> $stable(test_step) &&
                                                  $stable(test_idx);
  endproperty
  a_pause_hold: assert property (p_pause_hold) // see [R8]
    else $error("paused self-test moved");

  sequence s_charge_adv;
    adv && test_step == TS_CHARGE;
  endsequence
  property p_order;
    s_charge_adv |=> test_step == TS_LOAD;
  endproperty
  a_order: assert property (p_order) // see [R14]
    else $error("self-test did not go from charge to load");

  property p_single_bank;
    test_active ##1 $past(test_step) == TS_BANKS && test_active |->
      $onehot(bank_on);
  endproperty
  a_single_bank: assert property (p_single_bank) // see [R10]
    else $error("bank test drives more than one bank");

  property p_alarm;
    ##2 alarm_byte == {1'b0, $past(alarm_in, 3)};
  endproperty
  a_alarm: assert property (p_alarm) // see [R11]
    else $error("alarm byte does not mirror inputs");

  property p_mem_result;
    judge |=> mem_pass && !mem_fail;
  endproperty
  a_mem_result: assert property (p_mem_result) // see [R12]
    else $error("memory check result wrong");

endmodule

// ---- test/keypad_model.sv ----
// keypad and serial loop model facing the sequencer
`timescale 1ns/1ns
module keypad_model (
  input  wire logic core_clk,      // system clock
  input  wire logic serial_tx,     // sequencer serial output
  output logic      cal_key,       // calibration key, high pressed
  output logic      increment_key, // increment key, high pressed
  output logic      decrement_key, // decrement key, high pressed
  output logic      serial_rx      // looped serial input
);
  initial begin
    cal_key = 1'b0;
    increment_key = 1'b0;
    decrement_key = 1'b0;
  end
  // the tester ties serial output back to serial input
  assign serial_rx = serial_tx;
  // release between presses, else the edge detector sees one press
  task automatic press(input int k);
    @(posedge core_clk);
    #1;
    cal_key = (k == 0);
    increment_key = (k == 1);
    decrement_key = (k == 2);
    repeat (4) @(posedge core_clk);
    #1;
    {cal_key, increment_key, decrement_key} = 3'h0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  // self-test entry order: cal, inc, inc, cal
  task automatic enter_test();
    press(0);
    press(1);
    press(1);
    press(0);
  endtask
endmodule

// ---- test/tb_charge_bank_state_sequencer.sv ----
// self-checking testbench for the charge bank state sequencer
`timescale 1ns/1ns
module tb_charge_bank_state_sequencer;
  import charge_bank_pkg::*;
  localparam int SECS = 20; // shortened second keeps the run brief
  logic        core_clk  = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [11:0] batt_mv   = 12'h900;
  logic [7:0]  delay_sec = 8'h02;
  logic [6:0]  alarm_in  = 7'h00;
  wire         cal_key, increment_key, decrement_key, looped;
  wire  [3:0]  bank_on, shown_state;
  wire  [7:0]  alarm_byte;
  wire         charge_on, load_on, mem_pass, mem_fail, serial_tx;
  wire         test_active, test_paused;
  wire  [5:0]  outs = {charge_on, load_on, bank_on};
  int          failures = 0;
  int          num_checks = 0;
  int          n;

  always #50 core_clk = ~core_clk;

  charge_bank_state_sequencer #(.SEC_COUNT(SECS))
    charge_bank_state_sequencer_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .batt_mv(batt_mv),
    .boost_limit_mv(12'h800), .float_limit_mv(12'h800),
    .delay_sec(delay_sec), .cal_key(cal_key),
    .increment_key(increment_key), .decrement_key(decrement_key),
    .alarm_in(alarm_in), .bank_on(bank_on), .charge_on(charge_on),
    .load_on(load_on), .shown_state(shown_state),
    .alarm_byte(alarm_byte), .mem_pass(mem_pass), .mem_fail(mem_fail),
    .serial_tx(serial_tx), .test_active(test_active),
    .test_paused(test_paused));
  keypad_model keypad_model_i (
    .core_clk(core_clk), .serial_tx(serial_tx), .cal_key(cal_key),
    .increment_key(increment_key), .decrement_key(decrement_key),
    .serial_rx(looped));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // waits for any switch output to move; n is the cycles waited
  task automatic wait_outs(input int lim);
    logic [5:0] old;
    old = outs;
    n = 0;
    while (outs === old && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset();
    chk(bank_on, 4'hF, "reset banks");
    chk(shown_state, 4'h0, "reset state");
    chk({charge_on, load_on, serial_tx}, 3'h7, "reset switches");
    chk({test_active, test_paused, mem_pass}, 3'h0, "reset test");
    $display("test reset done");
  endtask
  // boost sheds bank D first, one step per two seconds
  task automatic test_boost();
    logic [3:0] m [4] = '{4'h7, 4'h3, 4'h1, 4'h0};
    for (int i = 0; i < 4; i++) begin
      wait_outs(4 * SECS);
      chk(bank_on, m[i], "boost mask");
      chk(shown_state, i + 1, "boost state");
      if (i > 0) chk(n, 2 * SECS, "boost delay");
    end
    wait_outs(3 * SECS);
    chk(shown_state, 4'h4, "float floor");
    $display("test boost done");
  endtask
  // float steps every second, up on low voltage, down on high
  task automatic test_float();
    logic [3:0] m [5] = '{4'h1, 4'h3, 4'h7, 4'hF, 4'h7};
    batt_mv = 12'h700;
    for (int i = 0; i < 5; i++) begin
      if (i == 4) batt_mv = 12'h900;
      wait_outs(2 * SECS);
      chk(bank_on, m[i], "float mask");
      chk(n, SECS, "float period");
    end
    chk(shown_state, 4'h7, "float state");
    $display("test float done");
  endtask
  task automatic test_alarm();
    alarm_in = 7'h45;
    cyc(4);
    chk(alarm_byte, 8'h45, "alarm byte");
    $display("test alarm done");
  endtask
  // entry, pause, resume, memory, banks, states, serial, then exit
  task automatic test_selftest();
    logic [3:0] m [13] = '{4'h2, 4'h4, 4'h8, 4'hF, 4'h7, 4'h3, 4'h1, 4'h0,
                           4'h1, 4'h3, 4'h7, 4'hF, 4'h0};
    keypad_model_i.enter_test();
    chk(test_active, 1'b1, "entry");
    chk(outs, 6'h20, "charge step");
    wait_outs(2 * SECS);
    chk(outs, 6'h10, "load step");
    keypad_model_i.press(1);
    chk(test_paused, 1'b1, "paused");
    cyc(3 * SECS);
    chk(outs, 6'h10, "frozen step");
    keypad_model_i.press(1);
    chk(test_paused, 1'b0, "resumed");
    n = 0;
    while (bank_on !== 4'h1 && n < 6 * SECS) begin
      cyc(1);
      n++;
    end
    chk({mem_pass, mem_fail}, 2'h2, "memory result");
    chk(bank_on, 4'h1, "bank A alone");
    for (int i = 0; i < 13; i++) begin
      wait_outs(2 * SECS);
      chk(bank_on, m[i], "test banks");
      chk(n, SECS, "test step time");
      if (i == 8) chk(shown_state, 4'h5, "test state index");
    end
    // serial step: the looped line shows the start bit
    chk(looped, 1'b0, "serial start bit");
    keypad_model_i.press(2);
    chk(test_active, 1'b0, "exit");
    // state 7 fell to 6 under one second before entry and stayed frozen
    chk(outs, 6'h33, "regulation resumes");
    chk(looped, 1'b1, "serial idle");
    $display("test selftest done");
  endtask

  initial begin
    cyc(2);
    sys_rst = 1'b0;
    test_reset();
    test_boost();
    test_float();
    test_alarm();
    test_selftest();
    wrap_up();
  end
  // watchdog at about 2.5 times the expected 800-cycle run
  initial begin
    #200_000;
    failures++;
    wrap_up();
  end
endmodule
